//--- slst_pkg.sv
`default_nettype none
package slst_pkg;
	localparam int NUM_PORTS = 4;
	localparam logic [7:0] ADDR_TALLY = 8'h57;
	localparam logic [7:0] ADDR_PORTSEL = 8'h4c;
	localparam logic [7:0] ADDR_CTRL = 8'hb3;
	localparam logic [7:0] ADDR_PINCTL = 8'hb4;
	localparam logic [7:0] ADDR_DEBUG = 8'hd0;
	localparam logic [7:0] SER_CFG_ADDR = 8'h14;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CLK_LSB = 1;
	localparam int CTRL_GATE_LSB = 6;
	localparam int PSEL_RD_LSB = 4;
	localparam int DBG_CHK_BIT = 0;
	localparam int DBG_ACT_BIT = 5;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PSEL_RST = 8'h01;
	localparam logic [7:0] PINCTL_RST = 8'h00;
	localparam logic [1:0] GATE_ON = 2'b10;
	localparam logic [1:0] PIN_PASS = 2'b01;
	localparam logic [1:0] PIN_LOCK = 2'b10;
	localparam logic [7:0] TALLY_MAX = 8'hfe;
	localparam logic [7:0] TALLY_FAIL = 8'hff;
	localparam logic [2:0] PRBS_LEN = 3'h7;
	localparam int PRBS_TAP_A = 6;
	localparam int PRBS_TAP_B = 5;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CFG = 2'b01,
		ST_RUN = 2'b10,
		ST_STOP = 2'b11
	} slst_state_type;
endpackage
`default_nettype wire

//--- slst_ctrl.sv
// Function
// - Writing 0x01 to control starts self test; writing zero stops it.
// - On start, write the remote serializer into self-test mode over back channel.
// - Each port checks the pattern continuously and counts each mismatch until its tally reaches 0xFE.
// - Each port has its own error tally, read at a paged offset.
// - Tally reads 0xFF without lock or after lock loss, else at most 0xFE.
// - Per-port pass signal, routable to pins, goes low for each error.
// - Debug register flag mirrors the remote serializer self-test active state.
// - Gating field 00 disables outputs during self test, 10 enables them.
// - Enabled outputs keep the camera port idle unless pattern generator runs.
// - Clock source field goes to serializer bits 2:1; zero means external.
// - Clock source is sampled at start; later changes have no effect.
// - Port window paged: two-bit read select, four write enables for broadcast.
// - Debug window uses the same read select and write enables.
// - Registers reachable from local I2C target and from control channel.
`default_nettype none
module slst_ctrl
	import slst_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset
	input wire logic i2c_wr, // I2C target write request
	input wire logic i2c_rd, // I2C target read request
	input wire logic [7:0] i2c_addr, // I2C register offset
	input wire logic [7:0] i2c_wdata, // I2C write data
	output logic i2c_ack, // I2C request done
	input wire logic cc_wr, // Control channel write request
	input wire logic cc_rd, // Control channel read request
	input wire logic [7:0] cc_addr, // Control channel offset
	input wire logic [7:0] cc_wdata, // Control channel write data
	output logic cc_ack, // Control channel request done
	output logic [7:0] rd_data, // Read data, valid with ack
	input wire logic [NUM_PORTS-1:0] rx_bit, // Recovered link bit per port
	input wire logic [NUM_PORTS-1:0] rx_bit_valid, // Bit strobe per port
	input wire logic [NUM_PORTS-1:0] rx_lock, // Receiver lock per port
	input wire logic [NUM_PORTS-1:0] remote_active, // Serializer reports self test on
	input wire logic pgen_enable, // Pattern generator drives video
	output logic bc_valid, // Back-channel write request
	input wire logic bc_ready, // Back-channel write accepted
	output logic [7:0] bc_addr, // Serializer register offset
	output logic [7:0] bc_wdata, // Serializer register data
	output logic [NUM_PORTS-1:0] pass, // Pass indication, low per error
	output logic [NUM_PORTS-1:0] gpio_out, // General-purpose pin levels
	output logic out_enable, // Device outputs enabled
	output logic csi_lp11 // Camera port held in idle
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [7:0] tally_step(input logic [7:0] cnt);
		return (cnt < TALLY_MAX) ? cnt + 8'h01 : TALLY_MAX;
	endfunction

	function automatic logic [7:0] tally_view(input logic [7:0] cnt, input logic seen,
		input logic lost);
		return (!seen || lost) ? TALLY_FAIL : cnt;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register access from both sources

	slst_state_type state, next_state;
	logic [7:0] ctrl, psel, pinctl;
	logic [1:0] clk_src_lat;
	logic [NUM_PORTS-1:0] chk_en, seen_lock, lost_lock, err;
	logic [PRBS_LEN-1:0] shreg [NUM_PORTS];
	logic [2:0] bitcnt [NUM_PORTS];
	logic [7:0] tally [NUM_PORTS];

	wire i2c_go = (i2c_wr | i2c_rd) & !i2c_ack;
	wire cc_go = (cc_wr | cc_rd) & !cc_ack & !i2c_go;
	wire req_wr = i2c_go ? i2c_wr : (cc_go & cc_wr);
	wire [7:0] req_addr = i2c_go ? i2c_addr : cc_addr;
	wire [7:0] req_wdata = i2c_go ? i2c_wdata : cc_wdata;
	wire wr_ctrl = req_wr & (req_addr == ADDR_CTRL);
	wire wr_psel = req_wr & (req_addr == ADDR_PORTSEL);
	wire wr_pin = req_wr & (req_addr == ADDR_PINCTL);
	wire wr_dbg = req_wr & (req_addr == ADDR_DEBUG);
	wire [1:0] rd_port = psel[PSEL_RD_LSB +: 2];
	wire [7:0] shown = tally_view(tally[rd_port], seen_lock[rd_port], lost_lock[rd_port]);
	wire [7:0] dbg_val = (8'(remote_active[rd_port]) << DBG_ACT_BIT) |
		(8'(chk_en[rd_port]) << DBG_CHK_BIT);
	wire [7:0] read_val = (req_addr == ADDR_TALLY) ? shown :
		(req_addr == ADDR_DEBUG) ? dbg_val :
		(req_addr == ADDR_CTRL) ? ctrl :
		(req_addr == ADDR_PORTSEL) ? psel :
		(req_addr == ADDR_PINCTL) ? pinctl : 8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RST;
			psel <= PSEL_RST;
			pinctl <= PINCTL_RST;
			i2c_ack <= 1'b0;
			cc_ack <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			if (wr_ctrl)
				ctrl <= req_wdata;
			if (wr_psel)
				psel <= req_wdata;
			if (wr_pin)
				pinctl <= req_wdata;
			i2c_ack <= i2c_go;
			cc_ack <= cc_go;
			if (i2c_go | cc_go)
				rd_data <= read_val;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			chk_en <= '1;
		else
			for (int p = 0; p < NUM_PORTS; p++)
				if (wr_dbg && psel[p])
					chk_en[p] <= req_wdata[DBG_CHK_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer and back-channel configuration

	wire start = (state == ST_IDLE) & ctrl[CTRL_EN_BIT];
	wire run = (state == ST_RUN);
	wire next_run = (next_state == ST_RUN);
	wire [1:0] next_clk_src = start ? ctrl[CTRL_CLK_LSB +: 2] : clk_src_lat;
	wire [1:0] gating = ctrl[CTRL_GATE_LSB +: 2];

	always_comb begin
		case (state)
			ST_IDLE: next_state = start ? ST_CFG : ST_IDLE;
			ST_CFG: next_state = bc_ready ? ST_RUN : ST_CFG;
			ST_RUN: next_state = ctrl[CTRL_EN_BIT] ? ST_RUN : ST_STOP;
			ST_STOP: next_state = bc_ready ? ST_IDLE : ST_STOP;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			clk_src_lat <= 2'b00;
			bc_valid <= 1'b0;
			bc_addr <= SER_CFG_ADDR;
			bc_wdata <= 8'h00;
		end else begin
			state <= next_state;
			clk_src_lat <= next_clk_src;
			bc_valid <= (next_state == ST_CFG) | (next_state == ST_STOP);
			bc_addr <= SER_CFG_ADDR;
			bc_wdata <= {5'h00, next_clk_src, next_state == ST_CFG};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pattern checkers, one per port

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++)
			err[p] = run & rx_bit_valid[p] & chk_en[p] & rx_lock[p] &
				(bitcnt[p] == PRBS_LEN) &
				(rx_bit[p] != (shreg[p][PRBS_TAP_A] ^ shreg[p][PRBS_TAP_B]));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				shreg[p] <= '0;
				bitcnt[p] <= 3'h0;
				tally[p] <= 8'h00;
			end
			seen_lock <= '0;
			lost_lock <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (start) begin
					tally[p] <= 8'h00;
					bitcnt[p] <= 3'h0;
					seen_lock[p] <= 1'b0;
					lost_lock[p] <= 1'b0;
				end else if (run) begin
					if (rx_lock[p])
						seen_lock[p] <= 1'b1;
					else if (seen_lock[p])
						lost_lock[p] <= 1'b1;
					if (!rx_lock[p])
						bitcnt[p] <= 3'h0;
					else if (rx_bit_valid[p] && chk_en[p]) begin
						shreg[p] <= {shreg[p][PRBS_LEN-2:0], rx_bit[p]};
						if (bitcnt[p] != PRBS_LEN)
							bitcnt[p] <= bitcnt[p] + 3'h1;
					end
					if (err[p])
						tally[p] <= tally_step(tally[p]);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins and output gating

	logic [NUM_PORTS-1:0] next_gpio;
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++)
			case (pinctl[2*i +: 2])
				PIN_PASS: next_gpio[i] = !err[i];
				PIN_LOCK: next_gpio[i] = rx_lock[i];
				default: next_gpio[i] = 1'b0;
			endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pass <= '1;
			gpio_out <= '0;
			out_enable <= 1'b1;
			csi_lp11 <= 1'b0;
		end else begin
			pass <= ~err;
			gpio_out <= next_gpio;
			out_enable <= !next_run | (gating == GATE_ON);
			csi_lp11 <= next_run & (gating == GATE_ON) & !pgen_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence seq_start;
		state == ST_IDLE && ctrl[CTRL_EN_BIT];
	endsequence

	sequence seq_cfg_issue;
		bc_valid && bc_wdata[0] && state == ST_CFG;
	endsequence

	AST_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
		seq_start |=> state == ST_CFG)
		else $error("self test did not start on enable");

	AST_CFG_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		seq_start |=> seq_cfg_issue ##0 bc_addr == SER_CFG_ADDR)
		else $error("no serializer configuration write at start");

	AST_CLK_FWD: assert property (@(posedge clk) disable iff (!rst_n)
		seq_start |=> bc_wdata[2:1] == $past(ctrl[CTRL_CLK_LSB +: 2]))
		else $error("clock source not forwarded");

	AST_CLK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		run && $past(run) |-> $stable(clk_src_lat))
		else $error("clock source changed while running");

	AST_GATE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		next_run && gating == 2'b00 |=> !out_enable)
		else $error("outputs not disabled during self test");

	AST_LP11: assert property (@(posedge clk) disable iff (!rst_n)
		next_run && gating == GATE_ON && !pgen_enable |=> csi_lp11 && out_enable)
		else $error("camera port not idle with outputs enabled");

	AST_TALLY_VIEW: assert property (@(posedge clk) disable iff (!rst_n)
		i2c_go && !i2c_wr && i2c_addr == ADDR_TALLY && lost_lock[rd_port]
		|=> i2c_ack && rd_data == TALLY_FAIL)
		else $error("lost lock tally does not read 0xff");

	for (genvar g = 0; g < NUM_PORTS; g++) begin : gen_chk
		AST_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
			err[g] && tally[g] < TALLY_MAX |=> tally[g] == $past(tally[g]) + 8'h01)
			else $error("error not counted");
		AST_SAT: assert property (@(posedge clk) disable iff (!rst_n)
			tally[g] <= TALLY_MAX)
			else $error("tally above 0xfe");
		AST_PASS: assert property (@(posedge clk) disable iff (!rst_n)
			err[g] |=> !pass[g] ##1 (pass[g] || $past(err[g])))
			else $error("pass not low for one cycle per error");
		AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
			seq_start |=> tally[g] == 8'h00 && !lost_lock[g])
			else $error("tally not cleared at start");
	end

endmodule
`default_nettype wire

//--- slst_ser_model.sv
`default_nettype none
module slst_ser_model
	import slst_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset
	input wire logic bc_valid, // Back-channel write request
	input wire logic [7:0] bc_addr, // Serializer register offset
	input wire logic [7:0] bc_wdata, // Serializer register data
	input wire logic [3:0] dly, // Cycles before accepting
	input wire logic [3:0] inj, // Flip the bit of a port
	output logic bc_ready, // Write accepted
	output logic [3:0] rx_bit, // Link bit per port
	output logic [3:0] rx_bit_valid, // Bit strobe per port
	output logic [3:0] remote_active // Self test running
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cfg;
	logic [7:0] crc_errs;
	logic [7:0] cfg_addr;
	logic [3:0] wait_cnt;
	logic [6:0] lfsr;
	logic tog;
	wire logic new_bit = lfsr[6] ^ lfsr[5];
	assign bc_ready = bc_valid && (wait_cnt >= dly);
	assign remote_active = {4{cfg[0]}};
	assign rx_bit_valid = {4{cfg[0]}};
	// Idle lines toggle so stale data never passes for pattern
	assign rx_bit = cfg[0] ? ({4{new_bit}} ^ inj) : {4{tog}};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= 8'h00;
			cfg_addr <= 8'h00;
			wait_cnt <= 4'h0;
			lfsr <= 7'h7f;
			tog <= 1'b0;
			crc_errs <= 8'h00;
		end else begin
			tog <= ~tog;
			wait_cnt <= (bc_valid && !bc_ready) ? wait_cnt + 4'h1 : 4'h0;
			lfsr <= cfg[0] ? {lfsr[5:0], new_bit} : 7'h7f;
			if (bc_ready) begin
				cfg <= bc_wdata;
				cfg_addr <= bc_addr;
				// Frames aimed at an unexpected register count as check failures
				if (bc_addr != SER_CFG_ADDR)
					crc_errs <= crc_errs + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

//--- serial_link_selftest_ctrl_tb_top.sv
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module serial_link_selftest_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import slst_pkg::*;
	logic clk, rst_n, i2c_wr, i2c_rd, cc_wr, cc_rd, i2c_ack, cc_ack;
	logic pgen_enable, bc_valid, bc_ready, out_enable, csi_lp11;
	logic [7:0] i2c_addr, i2c_wdata, cc_addr, cc_wdata, rd_data, bc_addr, bc_wdata, q;
	logic [3:0] rx_bit, rx_bit_valid, rx_lock, remote_active, pass, gpio_out, dly, inj;
	int failures = 0;
	int checks = 0;
	int low0 = 0;
	slst_ctrl slst_ctrl_inst (.clk, .rst_n, .i2c_wr, .i2c_rd, .i2c_addr, .i2c_wdata,
		.i2c_ack, .cc_wr, .cc_rd, .cc_addr, .cc_wdata, .cc_ack, .rd_data, .rx_bit,
		.rx_bit_valid, .rx_lock, .remote_active, .pgen_enable, .bc_valid, .bc_ready,
		.bc_addr, .bc_wdata, .pass, .gpio_out, .out_enable, .csi_lp11);
	slst_ser_model slst_ser_model_inst (.clk, .rst_n, .bc_valid, .bc_addr, .bc_wdata,
		.dly, .inj, .bc_ready, .rx_bit, .rx_bit_valid, .remote_active);
	always #25 clk = ~clk;
	always @(posedge clk) if (gpio_out[0] === 1'b0) low0++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic cc, input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		{i2c_wr, i2c_rd} <= cc ? 2'b00 : {wr, !wr};
		{cc_wr, cc_rd} <= cc ? {wr, !wr} : 2'b00;
		{i2c_addr, cc_addr} <= {a, a};
		{i2c_wdata, cc_wdata} <= {d, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((i2c_ack | cc_ack) !== 1'b1 && n < 20);
		q = rd_data;
		{i2c_wr, i2c_rd, cc_wr, cc_rd} <= 4'h0;
		if (n >= 20) begin
			failures++;
			final_report();
		end
	endtask
	task automatic rd(input logic cc, input logic [7:0] a, input logic [7:0] e);
		acc(cc, 1'b0, a, 8'h00);
		`CHK(q, e)
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b0, 1'b1, a, d);
	endtask
	task automatic sel(input logic [1:0] p);
		wr(ADDR_PORTSEL, {2'b00, p, 4'hf});
	endtask
	task automatic wait_act(input logic v);
		int n;
		n = 0;
		while (remote_active[0] !== v && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			failures++;
			final_report();
		end
	endtask
	task automatic final_report();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{clk, rst_n, i2c_wr, i2c_rd, cc_wr, cc_rd, pgen_enable} = '0;
		{i2c_addr, i2c_wdata, cc_addr, cc_wdata} = '0;
		{dly, inj} = '0;
		rx_lock = 4'hf;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(0, ADDR_CTRL, CTRL_RST);
		rd(1, ADDR_PORTSEL, PSEL_RST);
		wr(ADDR_TALLY, 8'h00);
		rd(0, ADDR_TALLY, TALLY_FAIL);
		rd(0, 8'h80, 8'h00);
		$display("test reset done");
		wr(ADDR_PINCTL, 8'h09);
		wr(ADDR_CTRL, 8'h83);
		wait_act(1'b1);
		`CHK(slst_ser_model_inst.cfg, 8'h03)
		`CHK(slst_ser_model_inst.cfg_addr, SER_CFG_ADDR)
		wr(ADDR_CTRL, 8'h85);
		repeat (20) @(posedge clk);
		`CHK(slst_ser_model_inst.cfg, 8'h03)
		`CHK({out_enable, csi_lp11, gpio_out[1]}, 3'b111)
		pgen_enable <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(csi_lp11, 1'b0)
		sel(2'd0);
		rd(0, ADDR_TALLY, 8'h00);
		rd(1, ADDR_DEBUG, 8'h21);
		$display("test start done");
		low0 = 0;
		inj <= 4'h1;
		@(posedge clk);
		inj <= 4'h8;
		repeat (300) @(posedge clk);
		`CHK(pass, 4'h7)
		inj <= 4'h0;
		rx_lock[2] <= 1'b0;
		repeat (3) @(posedge clk);
		rx_lock[2] <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK(low0, 3)
		rd(1, ADDR_TALLY, 8'h03);
		sel(2'd3);
		rd(0, ADDR_TALLY, TALLY_MAX);
		sel(2'd2);
		rd(0, ADDR_TALLY, TALLY_FAIL);
		$display("test errors done");
		wr(ADDR_CTRL, 8'h00);
		wait_act(1'b0);
		`CHK(slst_ser_model_inst.cfg, 8'h02)
		`CHK(slst_ser_model_inst.cfg[0], 1'b0)
		rd(0, ADDR_DEBUG, 8'h01);
		dly <= 4'h6;
		wr(ADDR_CTRL, 8'h01);
		wait_act(1'b1);
		`CHK(slst_ser_model_inst.cfg, 8'h01)
		repeat (3) @(posedge clk);
		`CHK(out_enable, 1'b0)
		sel(2'd0);
		rd(0, ADDR_TALLY, 8'h00);
		wr(ADDR_PORTSEL, 8'h06);
		wr(ADDR_DEBUG, 8'h00);
		rd(0, ADDR_DEBUG, 8'h21);
		wr(ADDR_PORTSEL, 8'h16);
		rd(1, ADDR_DEBUG, 8'h20);
		`CHK(slst_ser_model_inst.crc_errs, 8'h00)
		$display("test restart done");
		final_report();
	end
endmodule
`default_nettype wire
